// *** pfau_control.sv ***
// Purpose: Sequencing control that turns one order into strobe steps
// Assumes: Datapath answers every strobe on the next edge
// Notes: Division is not sequenced; fill digit is passed through
`timescale 1ns/1ns
`default_nettype none
module pfau_control
    import pfau_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    pfau_link_if.control link,
    input wire logic op_valid,
    input wire pfau_op_type op_code,
    input wire logic [WORD_W-1:0] mem_rdata,
    input wire logic fill_bit,
    output logic op_ready,
    output logic op_done,
    output logic [WORD_W-1:0] mem_wdata
);

    typedef enum logic [3:0] {
        S_IDLE, S_ONE, S_ADD_UP, S_ADD_LO, S_SHR_UP, S_SHR_LO,
        S_SHL_UP, S_SHL_LO, S_MUL_TEST, S_MUL_SIGN, S_DONE
    } pfau_state_type;

    pfau_state_type state_reg, state_next;
    pfau_op_type op_reg, op_next;
    logic [5:0] step_reg, step_next;
    pfau_strobe_type strobe;
    logic fix_phase;

    // After the last multiply step only the sign correction remains
    assign fix_phase = (step_reg == STEP_LAST);

    // Step sequencing; one order runs to completion unattended
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        step_next = step_reg;
        strobe = STROBE_IDLE;
        op_ready = 1'b0;
        op_done = 1'b0;
        unique case (state_reg)
            S_IDLE: begin
                op_ready = 1'b1;
                if (op_valid) begin
                    op_next = op_code; // see RULE18
                    step_next = STEP_RST;
                    unique case (op_code)
                        OP_ADD, OP_SUB: state_next = S_ADD_UP;
                        OP_RSH: state_next = S_SHR_UP;
                        OP_LSH: state_next = S_SHL_UP;
                        OP_MUL: state_next = S_MUL_TEST;
                        default: state_next = S_ONE;
                    endcase
                end
            end
            S_ONE: begin
                unique case (op_reg)
                    OP_ACC_MEM: strobe.acc_lo_mem = 1'b1;
                    OP_ACC_TAPE: strobe.acc_lo_tape = 1'b1;
                    OP_ACC_CLR: begin
                        strobe.acc_lo_clr = 1'b1;
                        strobe.acc_up_clr = 1'b1;
                    end
                    OP_AR_MEM: begin
                        // Clear and gate on one edge load the word
                        strobe.ar_up_clr = 1'b1; // see RULE21
                        strobe.ar_lo_clr = 1'b1;
                        strobe.ar_lo_mem = 1'b1;
                    end
                    OP_NUM_MEM: begin
                        strobe.num_clr = 1'b1; // see RULE21
                        strobe.num_mem = 1'b1;
                    end
                    OP_NUM_AR: begin
                        strobe.num_clr = 1'b1;
                        strobe.num_ar = 1'b1;
                    end
                    default: strobe = STROBE_IDLE;
                endcase
                state_next = S_DONE;
            end
            S_ADD_UP: begin
                // Subtract for SUB and for a negative multiplier's fix
                strobe.acc_up_sum = 1'b1;
                strobe.comp_on = (op_reg == OP_SUB) ||
                                 ((op_reg == OP_MUL) && fix_phase); // see RULE13
                state_next = S_ADD_LO;
            end
            S_ADD_LO: begin
                strobe.acc_lo_up = 1'b1;
                if (op_reg != OP_MUL) begin
                    state_next = S_DONE;
                end else if (fix_phase) begin
                    state_next = S_MUL_SIGN;
                end else begin
                    state_next = S_SHR_UP; // see RULE19
                end
            end
            S_SHR_UP: begin
                strobe.acc_up_shr = 1'b1; // see RULE17
                strobe.ar_up_shr = 1'b1;
                state_next = S_SHR_LO;
            end
            S_SHR_LO: begin
                strobe.acc_lo_up = 1'b1; // see RULE17
                strobe.ar_lo_up = 1'b1;
                if (op_reg == OP_MUL) begin
                    step_next = step_reg + 6'h01;
                    state_next = S_MUL_TEST;
                end else begin
                    state_next = S_DONE;
                end
            end
            S_SHL_UP: begin
                strobe.acc_up_shl = 1'b1; // see RULE17
                strobe.ar_up_shl = 1'b1;
                state_next = S_SHL_LO;
            end
            S_SHL_LO: begin
                strobe.acc_lo_up = 1'b1;
                strobe.ar_lo_up = 1'b1;
                state_next = S_DONE;
            end
            S_MUL_TEST: begin
                // Inspect AR least digit per step, then the sign at the end
                if (fix_phase) begin
                    state_next = link.ar_sign ? S_ADD_UP : S_MUL_SIGN; // see RULE20
                end else if (link.ar_lsb) begin
                    state_next = S_ADD_UP; // see RULE19
                end else begin
                    state_next = S_SHR_UP;
                end
            end
            S_MUL_SIGN: begin
                strobe.ar_sign_clr = 1'b1; // see RULE20
                state_next = S_DONE;
            end
            S_DONE: begin
                op_done = 1'b1;
                state_next = S_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            op_reg <= OP_ADD;
            step_reg <= STEP_RST;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            step_reg <= step_next;
        end
    end

    assign link.strobe = strobe; // see RULE21
    assign link.mem_word = mem_rdata;
    assign link.fill_bit = fill_bit;
    assign mem_wdata = link.acc_word;

endmodule
`default_nettype wire

// *** pfau_pkg.sv ***
// Purpose: Shared constants and types for the fixed-point arithmetic unit
// Assumes: One machine clock, active-low asynchronous reset
// Notes: Bit WORD_W-1 is the sign digit, bit 0 the least significant digit
package pfau_pkg;

    // Word layout
    localparam int WORD_W = 40;
    localparam int SIGN_POS = WORD_W - 1;
    localparam int LSB_POS = 0;
    localparam logic [39:0] WORD_ZERO = 40'h00_0000_0000;

    // Multiply loop length and counter reset value
    localparam int MUL_STEPS = 39;
    localparam logic [5:0] STEP_LAST = 6'h27;
    localparam logic [5:0] STEP_RST = 6'h00;

    // Clear and gate strobes from control to the datapath, one edge each
    typedef struct packed {
        logic acc_up_clr;  // Upper accumulator bank to zero
        logic acc_up_sum;  // Adder result into upper accumulator bank
        logic acc_up_copy; // Lower accumulator bank copied upward
        logic acc_up_shr;  // Lower bank shifted right into upper bank
        logic acc_up_shl;  // Lower bank shifted left into upper bank
        logic acc_lo_clr;  // Lower accumulator bank to zero
        logic acc_lo_up;   // Upper bank transferred down
        logic acc_lo_mem;  // Memory word into lower bank
        logic acc_lo_tape; // Input tape word into lower bank
        logic ar_up_clr;
        logic ar_up_copy;
        logic ar_up_shr;
        logic ar_up_shl;
        logic ar_lo_clr;
        logic ar_lo_up;
        logic ar_lo_mem;
        logic ar_sign_clr; // Sign digit of arithmetic register to zero
        logic num_clr;
        logic num_ar;      // Number register from arithmetic register
        logic num_mem;     // Number register from memory
        logic comp_on;     // Complement path into the adder
    } pfau_strobe_type;

    localparam pfau_strobe_type STROBE_IDLE = '0;

    // Orders accepted by the control
    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_RSH, OP_LSH, OP_MUL,
        OP_ACC_MEM, OP_ACC_TAPE, OP_ACC_CLR,
        OP_AR_MEM, OP_NUM_MEM, OP_NUM_AR
    } pfau_op_type;

endpackage

// *** pfau_link_if.sv ***
// Purpose: Connection between sequencing control and arithmetic datapath
// Assumes: Both ends clocked by core_clk
// Notes: Strobes are levels held one cycle per step
`timescale 1ns/1ns
`default_nettype none
interface pfau_link_if;
    import pfau_pkg::*;

    pfau_strobe_type strobe;
    logic [WORD_W-1:0] mem_word; // Word read from memory
    logic [WORD_W-1:0] acc_word; // Accumulator, the only path to memory
    logic fill_bit;              // Enters AR bottom on a left shift
    logic ar_lsb;                // Least digit of arithmetic register
    logic ar_sign;               // Sign digit of arithmetic register

    modport device (
        input strobe, mem_word, fill_bit,
        output acc_word, ar_lsb, ar_sign
    );
    modport control (
        output strobe, mem_word, fill_bit,
        input acc_word, ar_lsb, ar_sign
    );
endinterface
`default_nettype wire

// *** pfau_datapath.sv ***
// Purpose: Accumulator, arithmetic and number registers with adder
// Assumes: Control issues only meaningful strobe combinations per step
// Notes: Every bank changes only on a strobe; data leaves from flops
//
// Operation
// RULE1: Negation inverts all bits, adds one
// RULE2: Accumulator is 40-bit lower plus upper bank
// RULE3: Accumulator shifts left or right via upper
// RULE4: Sums enter upper bank, then move down
// RULE5: Accumulator alone feeds memory; loads tape words
// RULE6: Arithmetic register doubles; memory in, outputs out
// RULE7: Shifted-out digits pass between both registers
// RULE8: Number register loads from AR or memory
// RULE9: Number register feeds adder direct or complemented
// RULE10: Number register never shifts; no order path
// RULE11: Adder sums accumulator and number register mod 2
// RULE12: Carry out of sign position is dropped
// RULE13: Complement off gives sum, on gives difference
// RULE14: Right shift duplicates sign, halves the value
// RULE15: Right shift moves accumulator LSB into AR
// RULE16: Left shift keeps sign, zero fills, AR too; AR here shifts its sign digit out and takes the fill digit at the bottom
// RULE17: Control builds shifts from clear, gate strobes
// RULE18: One order starts a fully automatic sequence
// RULE19: Multiply is conditional adds with halvings
// RULE20: Thirty-nine steps, sign correction, clear AR sign
// RULE21: Each strobe acts on one edge; clear zeroes
`timescale 1ns/1ns
`default_nettype none
module pfau_datapath
    import pfau_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    pfau_link_if.device link,
    input wire logic [WORD_W-1:0] tape_word,
    output logic [WORD_W-1:0] acc_out,
    output logic [WORD_W-1:0] ar_out,
    output logic [WORD_W-1:0] num_out
);

    // Adder with carry into the least significant stage
    function automatic logic [WORD_W-1:0] add_word(
        input logic [WORD_W-1:0] a,
        input logic [WORD_W-1:0] b,
        input logic cin
    );
        logic [WORD_W:0] full;
        full = {1'b0, a} + {1'b0, b} + {{WORD_W{1'b0}}, cin};
        return full[WORD_W-1:0]; // see RULE12
    endfunction

    // Arithmetic right shift: sign copied into the top non-sign place
    function automatic logic [WORD_W-1:0] halve(
        input logic [WORD_W-1:0] w
    );
        return {w[SIGN_POS], w[SIGN_POS:1]}; // see RULE14
    endfunction

    // Doubling: sign held, digits up one place, zero at the bottom
    function automatic logic [WORD_W-1:0] double(
        input logic [WORD_W-1:0] w
    );
        return {w[SIGN_POS], w[SIGN_POS-2:0], 1'b0}; // see RULE16
    endfunction

    // The shift paths need a sign digit and at least two value digits
    if (WORD_W < 3) begin : g_word_check
        $error("word width too small for the shift paths");
    end

    logic [WORD_W-1:0] acc_up_reg, acc_up_next;
    logic [WORD_W-1:0] acc_lo_reg, acc_lo_next;
    logic [WORD_W-1:0] ar_up_reg, ar_up_next;
    logic [WORD_W-1:0] ar_lo_reg, ar_lo_next;
    logic [WORD_W-1:0] num_reg, num_next;
    logic [WORD_W-1:0] operand;
    logic [WORD_W-1:0] sum;
    pfau_strobe_type s;
    logic acc_drop;
    logic ar_fill;

    assign s = link.strobe;

    // Digits that cross between the registers during shifts; the one that
    // leaves the accumulator on a right shift would otherwise be lost
    assign acc_drop = acc_lo_reg[LSB_POS]; // see RULE7
    assign ar_fill = link.fill_bit;

    // Complement path: invert each digit and inject the last-place one,
    // which forms the negative of the number register word
    always_comb begin
        operand = s.comp_on ? ~num_reg : num_reg; // see RULE9 RULE1
        sum = add_word(acc_lo_reg, operand, s.comp_on); // see RULE11 RULE13
    end

    // Upper accumulator bank: the only place the adder result lands.
    // Clearing and gating on one edge acts as a load of the gated value.
    always_comb begin
        acc_up_next = acc_up_reg;
        if (s.acc_up_clr) begin
            acc_up_next = WORD_ZERO; // see RULE21
        end
        if (s.acc_up_sum) begin
            acc_up_next = sum; // see RULE4
        end else if (s.acc_up_copy) begin
            acc_up_next = acc_lo_reg;
        end else if (s.acc_up_shr) begin
            acc_up_next = halve(acc_lo_reg); // see RULE3
        end else if (s.acc_up_shl) begin
            acc_up_next = double(acc_lo_reg); // see RULE3
        end
    end

    // Lower accumulator bank: the working word seen by memory
    // Memory wins over tape if both are gated; control never asks both
    always_comb begin
        acc_lo_next = acc_lo_reg;
        if (s.acc_lo_clr) begin
            acc_lo_next = WORD_ZERO; // see RULE21
        end
        if (s.acc_lo_up) begin
            acc_lo_next = acc_up_reg; // see RULE4 RULE2
        end else if (s.acc_lo_mem) begin
            acc_lo_next = link.mem_word;
        end else if (s.acc_lo_tape) begin
            acc_lo_next = tape_word; // see RULE5
        end
    end

    // Upper arithmetic register bank. On a right shift the digit that
    // falls off the accumulator is caught here instead of being lost.
    always_comb begin
        ar_up_next = ar_up_reg;
        if (s.ar_up_clr) begin
            ar_up_next = WORD_ZERO; // see RULE21
        end
        if (s.ar_up_copy) begin
            ar_up_next = ar_lo_reg;
        end else if (s.ar_up_shr) begin
            // Sign kept, accumulator LSB into first non-sign place
            ar_up_next = {ar_lo_reg[SIGN_POS], acc_drop,
                          ar_lo_reg[SIGN_POS-1:1]}; // see RULE15 RULE7
        end else if (s.ar_up_shl) begin
            // All digits up one place, fill digit at the bottom
            ar_up_next = {ar_lo_reg[SIGN_POS-1:0],
                          ar_fill}; // see RULE16 RULE7
        end
    end

    // Lower arithmetic register bank
    // Sign clear acts last, so it also masks a load in the same step
    always_comb begin
        ar_lo_next = ar_lo_reg;
        if (s.ar_lo_clr) begin
            ar_lo_next = WORD_ZERO; // see RULE21
        end
        if (s.ar_lo_up) begin
            ar_lo_next = ar_up_reg; // see RULE6
        end else if (s.ar_lo_mem) begin
            ar_lo_next = link.mem_word; // see RULE6
        end
        if (s.ar_sign_clr) begin
            ar_lo_next[SIGN_POS] = 1'b0;
        end
    end

    // Number register: a single bank, loads only, never shifts, and it
    // has no route toward any order register
    always_comb begin
        num_next = num_reg;
        if (s.num_clr) begin
            num_next = WORD_ZERO; // see RULE21
        end
        if (s.num_ar) begin
            num_next = ar_lo_reg; // see RULE8 RULE10
        end else if (s.num_mem) begin
            num_next = link.mem_word; // see RULE8
        end
    end

    // All banks register on the machine clock
    // Reset zeroes every bank, so the first order sees clean words
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            acc_up_reg <= WORD_ZERO;
            acc_lo_reg <= WORD_ZERO;
            ar_up_reg <= WORD_ZERO;
            ar_lo_reg <= WORD_ZERO;
            num_reg <= WORD_ZERO;
        end else begin
            acc_up_reg <= acc_up_next;
            acc_lo_reg <= acc_lo_next;
            ar_up_reg <= ar_up_next;
            ar_lo_reg <= ar_lo_next;
            num_reg <= num_next;
        end
    end

    // Words to memory, printer and observer come straight from flops
    // The number register word is only observed; it never reaches orders
    assign link.acc_word = acc_lo_reg; // see RULE5
    assign link.ar_lsb = ar_lo_reg[LSB_POS];
    assign link.ar_sign = ar_lo_reg[SIGN_POS];
    assign acc_out = acc_lo_reg;
    assign ar_out = ar_lo_reg; // see RULE6
    assign num_out = num_reg;

endmodule
`default_nettype wire

// *** pfau_link_monitor.sv ***
// Purpose: Concurrent checks on the control to datapath link
// Assumes: One clock domain, rstn active low and asynchronous
// Notes: Helper flops keep older words for shift and memory load comparisons
`timescale 1ns/1ns
`default_nettype none
module pfau_link_monitor
    import pfau_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire pfau_strobe_type strobe,
    input wire logic [WORD_W-1:0] mem_word,
    input wire logic fill_bit,
    input wire logic [WORD_W-1:0] acc_word,
    input wire logic ar_lsb,
    input wire logic ar_sign
);
    logic [WORD_W-1:0] acc_q1_reg;
    logic [WORD_W-1:0] acc_q2_reg;
    logic [WORD_W-1:0] mem_q_reg;
    logic acc_lo_any;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Delayed copies, since a bit select of a past value is not portable
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            acc_q1_reg <= WORD_ZERO;
            acc_q2_reg <= WORD_ZERO;
            mem_q_reg <= WORD_ZERO;
        end else begin
            acc_q1_reg <= acc_word;
            acc_q2_reg <= acc_q1_reg;
            mem_q_reg <= mem_word;
        end
    end

    // Any strobe allowed to change the lower accumulator bank
    assign acc_lo_any = strobe.acc_lo_clr | strobe.acc_lo_up |
        strobe.acc_lo_mem | strobe.acc_lo_tape;

    // Shift results two edges after the upper bank gate; the other checks look at the same or the next edge
    AST_RSH: assert property (strobe.acc_up_shr |-> ##2
        acc_word == {acc_q2_reg[39], acc_q2_reg[39:1]})
        else $error("right shift gave wrong accumulator");
    AST_LSH: assert property (strobe.acc_up_shl |-> ##2
        acc_word == {acc_q2_reg[39], acc_q2_reg[37:0], 1'b0})
        else $error("left shift gave wrong accumulator");
    AST_AR_SHR_SIGN: assert property (strobe.ar_up_shr |-> ##2
        ar_sign == $past(ar_sign, 2))
        else $error("right shift lost the AR sign");
    AST_AR_SHL_FILL: assert property (strobe.ar_up_shl |-> ##2
        ar_lsb == $past(fill_bit, 2))
        else $error("left shift fill digit missing");
    AST_SHIFT_PAIR: assert property (strobe.acc_up_shr |->
        strobe.ar_up_shr)
        else $error("right shift not paired across registers");
    AST_SUM_DOWN: assert property (strobe.acc_up_sum |=>
        strobe.acc_lo_up)
        else $error("sum not moved down after capture");
    AST_ACC_MEM: assert property (strobe.acc_lo_mem &&
        !strobe.acc_lo_up |=> acc_word == $past(mem_word))
        else $error("memory word not loaded");
    AST_AR_MEM: assert property (strobe.ar_lo_mem &&
        !strobe.ar_lo_up && !strobe.ar_sign_clr |=>
        {ar_sign, ar_lsb} == {mem_q_reg[39], mem_q_reg[0]})
        else $error("AR memory load wrong");
    AST_ACC_CLR: assert property (strobe.acc_lo_clr &&
        !strobe.acc_lo_up && !strobe.acc_lo_mem && !strobe.acc_lo_tape
        |=> acc_word == WORD_ZERO)
        else $error("accumulator clear failed");
    AST_ACC_HOLD: assert property (!acc_lo_any |=>
        $stable(acc_word))
        else $error("accumulator changed with no strobe");
    AST_SIGN_CLR: assert property (strobe.ar_sign_clr |=>
        !ar_sign)
        else $error("AR sign not cleared");

    // Main scenarios reached
    CVR_SUB: cover property (strobe.acc_up_sum && strobe.comp_on);
    CVR_LSH: cover property (strobe.acc_up_shl);
    CVR_SIGN: cover property (strobe.ar_sign_clr);
    CVR_TAPE: cover property (strobe.acc_lo_tape);
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for control and datapath joined
// Assumes: Inputs change at the falling edge of core_clk
// Notes: Reference model follows the order definitions step by step
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            fails++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module tb_top;
    import pfau_pkg::*;
    logic core_clk, rstn, op_valid, fill_bit, op_ready, op_done;
    pfau_op_type op_code;
    logic [WORD_W-1:0] mem_rdata, tape_word, mem_wdata;
    logic [WORD_W-1:0] acc_out, ar_out, num_out;
    logic [WORD_W-1:0] m_acc, m_ar, m_num;
    logic [31:0] seed;
    int fails, comparisons, exp_lat;
    pfau_op_type c_op [14] = '{OP_NUM_MEM, OP_ACC_MEM, OP_SUB, OP_ADD,
        OP_ACC_TAPE, OP_AR_MEM, OP_NUM_AR, OP_RSH, OP_LSH, OP_AR_MEM,
        OP_ACC_CLR, OP_MUL, OP_AR_MEM, OP_MUL};
    logic [WORD_W-1:0] c_w [14] = '{40'h00_0000_0001, 40'h80_0000_0000,
        0, 0, 40'h7F_FFFF_FFFE, 40'hC0_0000_0000, 0, 0, 0,
        40'h40_0000_0000, 0, 0, 40'h80_0000_0001, 0};

    pfau_link_if link();
    pfau_control u_pfau_control (.core_clk, .rstn, .link(link), .op_valid,
        .op_code, .mem_rdata, .fill_bit, .op_ready, .op_done, .mem_wdata);
    pfau_datapath u_pfau_datapath (.core_clk, .rstn, .link(link),
        .tape_word, .acc_out, .ar_out, .num_out);
    pfau_link_monitor u_pfau_link_monitor (.core_clk, .rstn,
        .strobe(link.strobe), .mem_word(link.mem_word),
        .fill_bit(link.fill_bit), .acc_word(link.acc_word),
        .ar_lsb(link.ar_lsb), .ar_sign(link.ar_sign));

    // 100 MHz machine clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Xorshift source, fixed start for repeatable runs
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [39:0] rword();
        logic [31:0] h;
        h = rnd();
        return {h[7:0], rnd()};
    endfunction

    // Halving keeps the sign twice; AR takes the accumulator's last digit
    function automatic logic [79:0] f_shr(input logic [39:0] a, c);
        return {a[39], a[39:1], c[39], a[0], c[38:1]};
    endfunction

    // Expected registers and cycles to done for one order
    task automatic model(input pfau_op_type op, input logic [39:0] w,
        input logic f);
        exp_lat = 2;
        case (op)
            OP_ADD: m_acc = m_acc + m_num;
            OP_SUB: m_acc = m_acc + ~m_num + 40'h1;
            OP_RSH: {m_acc, m_ar} = f_shr(m_acc, m_ar);
            OP_LSH: {m_acc, m_ar} = {m_acc[39], m_acc[37:0], 1'b0,
                m_ar[38:0], f};
            OP_MUL: begin
                exp_lat = 120;
                for (int i = 0; i < MUL_STEPS; i++) begin
                    if (m_ar[0]) begin
                        m_acc = m_acc + m_num;
                        exp_lat += 2;
                    end
                    {m_acc, m_ar} = f_shr(m_acc, m_ar);
                end
                if (m_ar[39]) begin
                    m_acc = m_acc + ~m_num + 40'h1;
                    exp_lat += 2;
                end
                m_ar[39] = 1'b0;
            end
            OP_ACC_MEM: m_acc = w;
            OP_ACC_TAPE: m_acc = ~w;
            OP_ACC_CLR: m_acc = WORD_ZERO;
            OP_AR_MEM: m_ar = w;
            OP_NUM_MEM: m_num = w;
            OP_NUM_AR: m_num = m_ar;
            default: ;
        endcase
        if (op inside {OP_ADD, OP_SUB, OP_RSH, OP_LSH}) begin
            exp_lat = 3;
        end
    endtask

    // One order from offer to done; tape differs from memory on purpose
    task automatic run(input pfau_op_type op, input logic [39:0] w);
        int n;
        logic [31:0] r;
        r = rnd();
        op_valid = 1'b1;
        op_code = op;
        mem_rdata = w;
        tape_word = ~w;
        fill_bit = r[0];
        n = 0;
        while (op_ready !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        if (op_ready !== 1'b1) begin
            fails++;
            end_sim();
        end
        @(negedge core_clk);
        op_valid = 1'b0;
        `CHK(op_ready, 1'b0)
        n = 1;
        while (op_done !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        if (op_done !== 1'b1) begin
            fails++;
            end_sim();
        end
        model(op, w, r[0]);
        `CHK(n, exp_lat)
        `CHK(acc_out, m_acc)
        `CHK(ar_out, m_ar)
        `CHK(num_out, m_num)
        `CHK(mem_wdata, m_acc)
    endtask

    task end_sim();
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Reset, corner orders, then random orders
    initial begin
        seed = 32'h0000_5A90;
        rstn = 1'b0;
        op_valid = 1'b0;
        op_code = OP_ADD;
        mem_rdata = WORD_ZERO;
        tape_word = WORD_ZERO;
        fill_bit = 1'b0;
        m_acc = WORD_ZERO;
        m_ar = WORD_ZERO;
        m_num = WORD_ZERO;
        repeat (10) @(negedge core_clk);
        `CHK({acc_out, ar_out, num_out}, 120'h0)
        rstn = 1'b1;
        @(negedge core_clk);
        for (int i = 0; i < 14; i++) begin
            run(c_op[i], c_w[i]);
            if (i == 11) begin
                `CHK(acc_out, 40'hE0_0000_0000)
            end
        end
        for (int i = 0; i < 40; i++) begin
            run(pfau_op_type'(4'(rnd() % 32'd11)), rword());
        end
        end_sim();
    end
endmodule
`default_nettype wire
